// ==== verilog/pmbus_bank_regs.vh ====
/*
  Command codes, reset values, ranges and timing counts of the command bank.
  Assumes inclusion by the bank module only.
*/
`ifndef PMBUS_BANK_REGS_VH
`define PMBUS_BANK_REGS_VH
`define CMD_OVF_ACT      8'h41
`define CMD_OVW_THR      8'h42
`define CMD_OCF_THR      8'h46
`define CMD_OCF_ACT      8'h47
`define CMD_OCW_THR      8'h4A
`define CMD_OTF_THR      8'h4F
`define CMD_OTF_ACT      8'h50
`define CMD_OTW_THR      8'h51
`define CMD_VIN_THR      8'h55
`define CMD_PG_ON        8'h5E
`define CMD_PG_OFF       8'h5F
`define CMD_TON_DLY      8'h60
`define CMD_OUTPUT_RISE_TIME     8'h61
`define CMD_STAT_WORD    8'h79
`define CMD_STAT_VOUT    8'h7A
`define CMD_STAT_IOUT    8'h7B
`define CMD_STAT_IN      8'h7C
`define CMD_STAT_TEMP    8'h7D
`define CMD_STAT_CML     8'h7E
`define CMD_RD_VIN       8'h88
`define CMD_RD_VOUT      8'h8B
`define CMD_RD_IOUT      8'h8C
`define CMD_RD_TEMP      8'h8D
`define CMD_REV          8'h98
`define CMD_SEC_CFG      8'hE1
`define RST_OVF_ACT      8'hB8
`define RST_OCF_ACT      8'hF8
`define RST_OTF_ACT      8'hB8
`define RST_SEC_CFG      8'h00
`define RST_OVW_THR      16'hF000
`define RST_OCF_THR      16'hE3C0
`define RST_OCW_THR      16'hE320
`define RST_OTF_THR      16'hF1F4
`define RST_OTW_THR      16'hF1CC
`define RST_VIN_THR      16'hEB70
`define RST_PG_ON        16'hB000
`define RST_PG_OFF       16'h9000
`define RST_TON_DLY      16'hF814
`define RST_OUTPUT_RISE_TIME     16'hF828
`define RST_OV_FAULT     16'hF000
`define PROTOCOL_REV     8'h22
`define EXP_IOUT         5'h1C
`define EXP_TEMP         5'h1E
`define EXP_VIN          5'h1D
`define EXP_TIME         5'h1F
`define OVW_MIN          16'hB000
`define OVW_MAX          16'hFFFF
`define PG_MIN           16'h819A
`define PG_MAX           16'hD333
`define OC_MIN           12'h1E0
`define OC_MAX           12'h500
`define OTF_MIN          12'h064
`define OTF_MAX          12'h230
`define OTW_MIN          12'h064
`define OTW_MAX          12'h1F4
`define VIN_MIN          12'h180
`define VIN_MAX          12'h370
`define DLY_MIN          12'h00A
`define RISE_MIN         12'h01E
`define TIME_MAX         12'h3E8
`define RESP_FLD_HI      7
`define RETRY_FLD_HI     5
`define CML_BAD_CMD      7
`define CML_BAD_DATA     6
`define PG_BAD_BIT       11
`define TIME_LSB_NS      500000
`define CLK_PERIOD_NS    4
`define TICK_CYCLES      (`TIME_LSB_NS / `CLK_PERIOD_NS)
`endif

// ==== verilog/pmbus_command_bank.v ====
/*
  Command register bank of a digital power module, reached as an SMBus slave
  over clock and data pins, with limit checks, status and start-up sequencing.
  Assumes scl and sda come from the host asynchronously, measurements arrive
  in linear format on clk, and the pad resolves the open-drain data wire.
*/
`include "pmbus_bank_regs.vh"
`default_nettype none
module pmbus_command_bank #(
  parameter [6:0]  DEV_ADDR    = 7'h10,
  parameter        TICK_CYCLES = `TICK_CYCLES,
  parameter [15:0] OV_FAULT    = `RST_OV_FAULT
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        scl,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        start_req,
  input  wire [15:0] vin_meas,
  input  wire [15:0] vout_meas,
  input  wire [15:0] iout_meas,
  input  wire [15:0] temp_meas,
  output reg         output_enable,
  output reg         rise_active,
  output reg         power_good,
  output reg  [7:0]  secondary_on_off_pin
);
  localparam [2:0] B_IDLE = 3'h0, B_ADDR = 3'h1, B_ACKA = 3'h2, B_WR = 3'h3;
  localparam [2:0] B_ACKW = 3'h4, B_RD = 3'h5, B_ACKR = 3'h6;
  localparam [2:0] S_OFF = 3'h0, S_DELAY = 3'h1, S_RISE = 3'h2, S_ON = 3'h3;
  localparam [2:0] S_HOLD = 3'h4;

  reg  [2:0]  scl_sq, sda_sq, bus_q, seq_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  sh_q, tx_q, cmd_q, lo_q;
  reg  [1:0]  idx_q;
  reg         rw_q, nack_q;
  reg  [7:0]  ovf_act_q, ocf_act_q, otf_act_q;
  reg  [15:0] ovw_q, ocf_q, ocw_q, otf_q, otw_q;
  reg  [15:0] vin_q, pgon_q, pgoff_q, dly_q, rise_q;
  reg  [7:0]  cml_q, st_vout_q, st_iout_q, st_in_q, st_temp_q;
  reg  [31:0] tick_q;
  reg  [10:0] step_q;
  reg  [15:0] rd_w;
  reg         wr_known, wr_word, wr_range;
  reg  [7:0]  act;
  wire        scl_rise = scl_sq[1] & ~scl_sq[2];
  wire        scl_fall = ~scl_sq[1] & scl_sq[2];
  wire        bus_start = scl_sq[1] & scl_sq[2] & sda_sq[2] & ~sda_sq[1];
  wire        bus_stop = scl_sq[1] & scl_sq[2] & ~sda_sq[2] & sda_sq[1];
  wire [15:0] wdata = {sh_q, lo_q};
  wire        byte_end = scl_fall & (bit_q == 4'h8);
  wire        wr_byte = (bus_q == B_WR) & byte_end;
  wire        commit = wr_byte & wr_known & (idx_q == (wr_word ? 2'h2 : 2'h1));
  wire        bad_cmd = wr_byte & (idx_q != 2'h0) & ~wr_known;
  wire        tick = (tick_q == TICK_CYCLES - 1);
  wire        ov_flt = vout_meas > OV_FAULT;
  wire        ov_warn = vout_meas > ovw_q;
  wire        oc_flt = iout_meas[10:0] > ocf_q[10:0];
  wire        oc_warn = iout_meas[10:0] > ocw_q[10:0];
  wire        ot_flt = temp_meas[10:0] > otf_q[10:0];
  wire        ot_warn = temp_meas[10:0] > otw_q[10:0];
  wire        vin_flt = vin_meas[10:0] > vin_q[10:0];
  wire        act_flt = ov_flt | oc_flt | ot_flt;
  wire        cml_rd = (bus_q == B_ACKA) & scl_fall & rw_q & (cmd_q == `CMD_STAT_CML);

  function lin_ok;
    input [15:0] w;
    input [4:0]  e;
    input [11:0] lo;
    input [11:0] hi;
    begin
      lin_ok = (w[15:11] == e) & ~w[10] & ({1'b0, w[10:0]} >= lo) &
               ({1'b0, w[10:0]} <= hi);
    end
  endfunction

  always @* begin
    wr_known = 1'b1;
    wr_word = 1'b1;
    wr_range = 1'b1;
    if (cmd_q == `CMD_OVF_ACT || cmd_q == `CMD_OCF_ACT || cmd_q == `CMD_OTF_ACT ||
        cmd_q == `CMD_SEC_CFG) begin
      wr_word = 1'b0;
    end else if (cmd_q == `CMD_OVW_THR) begin
      wr_range = (wdata >= `OVW_MIN) & (wdata <= `OVW_MAX);
    end else if (cmd_q == `CMD_OCF_THR || cmd_q == `CMD_OCW_THR) begin
      wr_range = lin_ok(wdata, `EXP_IOUT, `OC_MIN, `OC_MAX);
    end else if (cmd_q == `CMD_OTF_THR) begin
      wr_range = lin_ok(wdata, `EXP_TEMP, `OTF_MIN, `OTF_MAX);
    end else if (cmd_q == `CMD_OTW_THR) begin
      wr_range = lin_ok(wdata, `EXP_TEMP, `OTW_MIN, `OTW_MAX);
    end else if (cmd_q == `CMD_VIN_THR) begin
      wr_range = lin_ok(wdata, `EXP_VIN, `VIN_MIN, `VIN_MAX);
    end else if (cmd_q == `CMD_PG_ON || cmd_q == `CMD_PG_OFF) begin
      wr_range = (wdata >= `PG_MIN) & (wdata <= `PG_MAX);
    end else if (cmd_q == `CMD_TON_DLY) begin
      wr_range = lin_ok(wdata, `EXP_TIME, `DLY_MIN, `TIME_MAX);
    end else if (cmd_q == `CMD_OUTPUT_RISE_TIME) begin
      wr_range = lin_ok(wdata, `EXP_TIME, `RISE_MIN, `TIME_MAX);
    end else begin
      wr_known = 1'b0;
    end
  end

  always @* begin
    rd_w = 16'hFFFF;
    if (cmd_q == `CMD_OVF_ACT) begin
      rd_w = {8'h00, ovf_act_q};
    end else if (cmd_q == `CMD_OVW_THR) begin
      rd_w = ovw_q;
    end else if (cmd_q == `CMD_OCF_THR) begin
      rd_w = ocf_q;
    end else if (cmd_q == `CMD_OCF_ACT) begin
      rd_w = {8'h00, ocf_act_q};
    end else if (cmd_q == `CMD_OCW_THR) begin
      rd_w = ocw_q;
    end else if (cmd_q == `CMD_OTF_THR) begin
      rd_w = otf_q;
    end else if (cmd_q == `CMD_OTF_ACT) begin
      rd_w = {8'h00, otf_act_q};
    end else if (cmd_q == `CMD_OTW_THR) begin
      rd_w = otw_q;
    end else if (cmd_q == `CMD_VIN_THR) begin
      rd_w = vin_q;
    end else if (cmd_q == `CMD_PG_ON) begin
      rd_w = pgon_q;
    end else if (cmd_q == `CMD_PG_OFF) begin
      rd_w = pgoff_q;
    end else if (cmd_q == `CMD_TON_DLY) begin
      rd_w = dly_q;
    end else if (cmd_q == `CMD_OUTPUT_RISE_TIME) begin
      rd_w = rise_q;
    end else if (cmd_q == `CMD_STAT_WORD) begin
      rd_w = {st_vout_q[7] | st_vout_q[6], st_iout_q[7] | st_iout_q[5], st_in_q[7],
              1'b0, ~power_good, 3'h0, 1'b0, ~output_enable, 3'h0,
              st_temp_q[7] | st_temp_q[6], |cml_q, 1'b0};
    end else if (cmd_q == `CMD_STAT_VOUT) begin
      rd_w = {8'h00, st_vout_q};
    end else if (cmd_q == `CMD_STAT_IOUT) begin
      rd_w = {8'h00, st_iout_q};
    end else if (cmd_q == `CMD_STAT_IN) begin
      rd_w = {8'h00, st_in_q};
    end else if (cmd_q == `CMD_STAT_TEMP) begin
      rd_w = {8'h00, st_temp_q};
    end else if (cmd_q == `CMD_STAT_CML) begin
      rd_w = {8'h00, cml_q};
    end else if (cmd_q == `CMD_RD_VIN) begin
      rd_w = vin_meas;
    end else if (cmd_q == `CMD_RD_VOUT) begin
      rd_w = vout_meas;
    end else if (cmd_q == `CMD_RD_IOUT) begin
      rd_w = iout_meas;
    end else if (cmd_q == `CMD_RD_TEMP) begin
      rd_w = temp_meas;
    end else if (cmd_q == `CMD_REV) begin
      rd_w = {8'h00, `PROTOCOL_REV};
    end else if (cmd_q == `CMD_SEC_CFG) begin
      rd_w = {8'h00, secondary_on_off_pin};
    end
  end

  /* Bus engine: pins pass three flip-flops, edges are found between the second and the third. */
  always @(posedge clk) begin
    if (!rst_b) begin
      scl_sq <= 3'h7;
      sda_sq <= 3'h7;
      bus_q <= B_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      lo_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_sq <= {scl_sq[1:0], scl};
      sda_sq <= {sda_sq[1:0], sda_in};
      if (bus_start) begin
        bus_q <= B_ADDR;
        bit_q <= 4'h0;
        idx_q <= 2'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        bus_q <= B_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (bus_q == B_ADDR || bus_q == B_WR || bus_q == B_RD) begin
          sh_q <= {sh_q[6:0], sda_sq[2]};
          bit_q <= bit_q + 4'h1;
        end
        if (bus_q == B_ACKR) begin
          nack_q <= sda_sq[2];
        end
      end else if (scl_fall) begin
        case (bus_q)
          B_ADDR: begin
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              rw_q <= sh_q[0];
              bus_q <= (sh_q[7:1] == DEV_ADDR) ? B_ACKA : B_IDLE;
              sda_oe <= (sh_q[7:1] == DEV_ADDR);
            end
          end
          B_ACKA: begin
            if (rw_q) begin
              bus_q <= B_RD;
              sda_oe <= ~rd_w[7];
              tx_q <= {rd_w[6:0], 1'b0};
              idx_q <= 2'h1;
            end else begin
              bus_q <= B_WR;
              sda_oe <= 1'b0;
            end
          end
          B_WR: begin
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (idx_q == 2'h0) begin
                cmd_q <= sh_q;
              end
              if (idx_q == 2'h1) begin
                lo_q <= sh_q;
              end
              if (idx_q != 2'h3) begin
                idx_q <= idx_q + 2'h1;
              end
              bus_q <= B_ACKW;
              sda_oe <= 1'b1;
            end
          end
          B_ACKW: begin
            bus_q <= B_WR;
            sda_oe <= 1'b0;
          end
          B_RD: begin
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              bus_q <= B_ACKR;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          B_ACKR: begin
            if (nack_q) begin
              bus_q <= B_IDLE;
            end else begin
              bus_q <= B_RD;
              sda_oe <= (idx_q == 2'h1) ? ~rd_w[15] : 1'b0;
              tx_q <= (idx_q == 2'h1) ? {rd_w[14:8], 1'b0} : 8'hFE;
              idx_q <= 2'h2;
            end
          end
          default: begin
            bus_q <= B_IDLE;
          end
        endcase
      end
    end
  end

  /* Writable commands and status flags. */
  always @(posedge clk) begin
    if (!rst_b) begin
      ovf_act_q <= `RST_OVF_ACT;
      ocf_act_q <= `RST_OCF_ACT;
      otf_act_q <= `RST_OTF_ACT;
      secondary_on_off_pin <= `RST_SEC_CFG;
      ovw_q <= `RST_OVW_THR;
      ocf_q <= `RST_OCF_THR;
      ocw_q <= `RST_OCW_THR;
      otf_q <= `RST_OTF_THR;
      otw_q <= `RST_OTW_THR;
      vin_q <= `RST_VIN_THR;
      pgon_q <= `RST_PG_ON;
      pgoff_q <= `RST_PG_OFF;
      dly_q <= `RST_TON_DLY;
      rise_q <= `RST_OUTPUT_RISE_TIME;
      cml_q <= 8'h00;
      st_vout_q <= 8'h00;
      st_iout_q <= 8'h00;
      st_in_q <= 8'h00;
      st_temp_q <= 8'h00;
      power_good <= 1'b0;
    end else begin
      if (commit && wr_range) begin
        if (cmd_q == `CMD_OVF_ACT) ovf_act_q <= sh_q;
        if (cmd_q == `CMD_OCF_ACT) ocf_act_q <= sh_q;
        if (cmd_q == `CMD_OTF_ACT) otf_act_q <= sh_q;
        if (cmd_q == `CMD_SEC_CFG) secondary_on_off_pin <= sh_q;
        if (cmd_q == `CMD_OVW_THR) ovw_q <= wdata;
        if (cmd_q == `CMD_OCF_THR) ocf_q <= wdata;
        if (cmd_q == `CMD_OCW_THR) ocw_q <= wdata;
        if (cmd_q == `CMD_OTF_THR) otf_q <= wdata;
        if (cmd_q == `CMD_OTW_THR) otw_q <= wdata;
        if (cmd_q == `CMD_VIN_THR) vin_q <= wdata;
        if (cmd_q == `CMD_PG_ON) pgon_q <= wdata;
        if (cmd_q == `CMD_PG_OFF) pgoff_q <= wdata;
        if (cmd_q == `CMD_TON_DLY) dly_q <= wdata;
        if (cmd_q == `CMD_OUTPUT_RISE_TIME) rise_q <= wdata;
      end
      cml_q[`CML_BAD_DATA] <= (commit & ~wr_range) |
                              (cml_q[`CML_BAD_DATA] & ~cml_rd);
      cml_q[`CML_BAD_CMD] <= bad_cmd | (cml_q[`CML_BAD_CMD] & ~cml_rd);
      st_vout_q <= {ov_flt, ov_warn, 6'h00};
      st_iout_q <= {oc_flt, 1'b0, oc_warn, 5'h00};
      st_in_q <= {vin_flt, 7'h00};
      st_temp_q <= {ot_flt, ot_warn, 6'h00};
      if (vout_meas >= pgon_q) begin
        power_good <= 1'b1;
      end else if (vout_meas <= pgoff_q) begin
        power_good <= 1'b0;
      end
    end
  end

  /* Start-up sequencer, counting half-millisecond time steps. */
  always @* begin
    if (ov_flt) begin
      act = ovf_act_q;
    end else if (oc_flt) begin
      act = ocf_act_q;
    end else begin
      act = otf_act_q;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      seq_q <= S_OFF;
      tick_q <= 32'h0;
      step_q <= 11'h000;
      output_enable <= 1'b0;
      rise_active <= 1'b0;
    end else begin
      tick_q <= (tick || seq_q == S_OFF) ? 32'h0 : tick_q + 32'h1;
      step_q <= tick ? step_q + 11'h001 : step_q;
      if (!start_req) begin
        seq_q <= S_OFF;
      end else if ((seq_q == S_RISE || seq_q == S_ON) &&
                   ((act_flt && act[`RESP_FLD_HI:`RESP_FLD_HI-1] != 2'h0) || vin_flt)) begin
        seq_q <= (!act_flt || act[`RETRY_FLD_HI:`RETRY_FLD_HI-2] != 3'h0) ?
                 S_DELAY : S_HOLD;
        step_q <= 11'h000;
        tick_q <= 32'h0;
      end else if (seq_q == S_OFF) begin
        seq_q <= S_DELAY;
        step_q <= 11'h000;
      end else if (seq_q == S_DELAY && step_q >= dly_q[10:0]) begin
        seq_q <= S_RISE;
        step_q <= 11'h000;
        tick_q <= 32'h0;
      end else if (seq_q == S_RISE && step_q >= rise_q[10:0]) begin
        seq_q <= S_ON;
      end
      output_enable <= (seq_q == S_RISE) | (seq_q == S_ON);
      rise_active <= (seq_q == S_RISE);
    end
  end
endmodule // pmbus_command_bank
`default_nettype wire

// ==== sim/pmbus_command_bank_monitor.sv ====
/* Checker for the command bank ports: sequencing, power good, config pin.
   Assumes a bind to pmbus_command_bank with default delay and rise words. */
`default_nettype none
module pmbus_command_bank_monitor #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        sda_oe,
  input wire logic        start_req,
  input wire logic [15:0] vout_meas,
  input wire logic        output_enable,
  input wire logic        rise_active,
  input wire logic        power_good,
  input wire logic [7:0]  secondary_on_off_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 20 * TICK_CYCLES - 4;
  localparam int RISE = 40 * TICK_CYCLES - 4;
  logic [15:0] wait_q;
  logic [15:0] rise_q;
  // Counts cycles spent waiting with a start request, and cycles of rise.
  always @(posedge clk) begin
    wait_q <= (start_req && !output_enable) ? wait_q + 16'h0001 : 16'h0000;
    rise_q <= rise_active ? rise_q + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_b |=> !sda_oe && !output_enable && !power_good && secondary_on_off_pin == 8'h00)
    else $error("outputs not cleared by reset");
  a_rise_on: assert property (rise_active |-> output_enable)
    else $error("rise without output enable");
  a_on_via_rise: assert property ($rose(output_enable) |-> rise_active)
    else $error("output on without rise");
  a_stop_off: assert property ($fell(start_req) |-> ##2 !output_enable && !rise_active)
    else $error("output stays on after stop");
  a_delay_len: assert property ($rose(rise_active) |-> wait_q >= DLY)
    else $error("turn-on delay too short");
  a_rise_len: assert property ($fell(rise_active) && output_enable |-> rise_q >= RISE)
    else $error("rise time too short");
  a_good_set: assert property (vout_meas >= 16'hB000 [*3] |-> power_good)
    else $error("power good not set");
  a_good_clear: assert property (vout_meas <= 16'h9000 [*3] |-> !power_good)
    else $error("power good not cleared");
  a_pin_by_bus: assert property ($changed(secondary_on_off_pin) |-> ##[0:8] sda_oe)
    else $error("config pin changed without bus write");
  c_rise: cover property ($rose(rise_active));
  c_good_drop: cover property ($fell(power_good));
  c_ack: cover property ($rose(sda_oe));
endmodule // pmbus_command_bank_monitor
`default_nettype wire

// ==== sim/smbus_host_model.sv ====
/* Bus host model: clock and open-drain data of the command bank's bus.
   Assumes the bench resolves the data wire from both pull-down enables. */
`default_nettype none
module smbus_host_model #(
  parameter logic [6:0] ADDR = 7'h10
) (
  input  wire logic        clk,
  input  wire logic        sda_line,
  output var  logic        scl,
  output var  logic        sda_low,
  output var  logic        rd_valid,
  output var  logic [15:0] rd_data,
  output var  logic        ack_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1;
    sda_low = 0;
    rd_valid = 0;
    rd_data = 16'h0000;
    ack_ok = 1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 0;
    hw(10);
    scl = 1;
    hw(10);
    sda_low = 1;
    hw(10);
    scl = 0;
    hw(10);
  endtask
  task automatic stop();
    sda_low = 1;
    hw(10);
    scl = 1;
    hw(10);
    sda_low = 0;
    hw(20);
  endtask
  // One bit: data set while the clock is low, sampled mid-way through high.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hw(10);
    scl = 1;
    hw(10);
    r = sda_line;
    hw(10);
    scl = 0;
    hw(10);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ak, input logic chk,
                         output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, a);
    if (chk) ack_ok = ack_ok & !a;
  endtask
  task automatic write(input logic [7:0] cmd, input logic [15:0] v, input int n,
                       input logic [6:0] adr = ADDR);
    logic [7:0] q;
    ack_ok = 1;
    start();
    byte_io({adr, 1'b0}, 1, 1, q);
    byte_io(cmd, 1, 1, q);
    byte_io(v[7:0], 1, 1, q);
    if (n > 1) byte_io(v[15:8], 1, 1, q);
    stop();
  endtask
  task automatic read(input logic [7:0] cmd, input int n);
    logic [7:0] lo;
    logic [7:0] hi;
    hi = 8'h00;
    ack_ok = 1;
    start();
    byte_io({ADDR, 1'b0}, 1, 1, lo);
    byte_io(cmd, 1, 1, lo);
    start();
    byte_io({ADDR, 1'b1}, 1, 1, lo);
    byte_io(8'hFF, n < 2, 0, lo);
    if (n > 1) byte_io(8'hFF, 1, 0, hi);
    stop();
    rd_data = {hi, lo};
    rd_valid = 1;
    hw(1);
    rd_valid = 0;
  endtask
endmodule // smbus_host_model
`default_nettype wire

// ==== sim/pmbus_command_bank_tb_top.sv ====
/* Self-checking bench of the command bank: host model, telemetry, queued reads.
   Assumes the monitor and host model are compiled before this file. */
`default_nettype none
module pmbus_command_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, start_req, scl, host_low, rd_valid, ack_ok;
  logic        sda_out, sda_oe, oe, rise, pg;
  logic [15:0] vin, vout, iout, temp, rd_data;
  logic [7:0]  sec, p;
  logic [31:0] exp_q[$];
  logic [31:0] r, e;
  int          err_count, samples_checked, cyc, n;
  wire         sda_line = !(sda_oe | host_low);
  logic [7:0]  acts[4] = '{8'h41, 8'h47, 8'h50, 8'hE1};
  logic [31:0] dflt[15] = '{32'h410100B8, 32'h4202F000, 32'h4602E3C0, 32'h470100F8,
    32'h4A02E320, 32'h4F02F1F4, 32'h500100B8, 32'h5102F1CC, 32'h5502EB70, 32'h5E02B000,
    32'h5F029000, 32'h6002F814, 32'h6102F828, 32'h98010022, 32'hE1010000};
  pmbus_command_bank #(.TICK_CYCLES(4)) uut (.clk(clk), .rst_b(rst_b), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .start_req(start_req),
    .vin_meas(vin), .vout_meas(vout), .iout_meas(iout), .temp_meas(temp),
    .output_enable(oe), .rise_active(rise), .power_good(pg), .secondary_on_off_pin(sec));
  smbus_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low),
    .rd_valid(rd_valid), .rd_data(rd_data), .ack_ok(ack_ok));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ev);
    samples_checked++;
    if (seen !== ev) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ev, seen);
    end
  endtask
  task automatic rd(input logic [7:0] c, input int k, input logic [15:0] m,
                    input logic [15:0] v);
    exp_q.push_back({m, v & m});
    host.read(c, k);
  endtask
  task automatic wait_hi(ref logic s, input logic lvl);
    n = 0;
    while (s !== lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic settle(input logic [15:0] v);
    vout = v;
    repeat (5) @(negedge clk);
  endtask
  task automatic results();
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 95000) begin
      err_count++;
      results();
    end
    if (rd_valid === 1'b1) begin
      e = exp_q.pop_front();
      check("read", rd_data & e[31:16], e[15:0]);
    end
  end
  initial begin
    rst_b = 0;
    start_req = 0;
    vin = 16'hE9B0;
    vout = 16'hA000;
    iout = 16'hE100;
    temp = 16'hF064;
    r = $urandom(89165);
    repeat (16) @(negedge clk);
    rst_b = 1;
    repeat (8) @(negedge clk);
    // Reset values.
    foreach (dflt[i]) rd(dflt[i][31:24], dflt[i][23:16], 16'hFFFF, dflt[i][15:0]);
    for (int c = 0; c < 4; c++) begin
      r = $urandom;
      host.write(acts[c], {8'h00, r[7:0]}, 1);
      rd(acts[c], 1, 16'h00FF, {8'h00, r[7:0]});
    end
    p = r[7:0];
    check("pin", {8'h00, sec}, {8'h00, p});
    r = 32'h1E0 + $urandom % 32'h100;
    // Warning stays below the fault threshold.
    host.write(8'h4A, {5'h1C, r[10:0]}, 2);
    rd(8'h4A, 2, 16'hFFFF, {5'h1C, r[10:0]});
    host.write(8'hE1, {8'h00, ~p}, 1, 7'h11);
    check("nack", {15'h0, ack_ok}, 16'h0000);
    check("pin_kept", {8'h00, sec}, {8'h00, p});
    check("sda_out", {15'h0, sda_out}, 16'h0000);
    host.write(8'h46, 16'hE100, 2);
    host.write(8'h46, 16'hF3C0, 2);
    host.write(8'h79, 16'h0000, 2);
    host.write(8'h42, 16'h1000, 2);
    host.write(8'h51, 16'hF0C8, 2);
    rd(8'h46, 2, 16'hFFFF, 16'hE3C0);
    rd(8'h42, 2, 16'hFFFF, 16'hF000);
    rd(8'h51, 2, 16'hFFFF, 16'hF0C8);
    rd(8'h79, 2, 16'h0002, 16'h0002);
    rd(8'h7E, 1, 16'h00C0, 16'h00C0);
    rd(8'h79, 2, 16'h0002, 16'h0000);
    r = $urandom;
    vin = {5'h1D, 2'b00, r[8:0]};
    vout = 16'hB000 + {2'b00, r[13:0]};
    iout = {5'h1C, 3'b000, r[7:0]};
    temp = {5'h1E, 3'b000, r[15:8]};
    rd(8'h88, 2, 16'hFFFF, vin);
    rd(8'h8B, 2, 16'hFFFF, vout);
    rd(8'h8C, 2, 16'hFFFF, iout);
    rd(8'h8D, 2, 16'hFFFF, temp);
    vout = 16'hF800;
    iout = 16'hE3F0;
    temp = 16'hF1E0;
    vin = 16'hEB78;
    rd(8'h7A, 1, 16'h00C0, 16'h00C0);
    rd(8'h7B, 1, 16'h00A0, 16'h00A0);
    rd(8'h7C, 1, 16'h0080, 16'h0080);
    rd(8'h7D, 1, 16'h00C0, 16'h0040);
    rd(8'h79, 2, 16'hE804, 16'hE004);
    vout = 16'hC000;
    iout = 16'hE100;
    temp = 16'hF064;
    vin = 16'hE9B0;
    start_req = 1;
    wait_hi(rise, 1);
    check("delay", {15'h0, n >= 80 && n <= 84}, 16'h0001);
    wait_hi(rise, 0);
    check("rise", {15'h0, n >= 158 && n <= 164}, 16'h0001);
    check("on", {14'h0, oe, pg}, 16'h0003);
    settle(16'hA000);
    check("pg_hold", {15'h0, pg}, 16'h0001);
    settle(16'h9000);
    check("pg_off", {15'h0, pg}, 16'h0000);
    settle(16'hA000);
    check("pg_low", {15'h0, pg}, 16'h0000);
    rd(8'h79, 2, 16'h0800, 16'h0800);
    settle(16'hB000);
    check("pg_on", {15'h0, pg}, 16'h0001);
    host.write(8'h47, 16'h00C0, 1);
    iout = 16'hE3F0;
    repeat (300) @(negedge clk);
    iout = 16'hE100;
    repeat (300) @(negedge clk);
    check("hold_off", {15'h0, oe}, 16'h0000);
    start_req = 0;
    repeat (4) @(negedge clk);
    start_req = 1;
    wait_hi(rise, 1);
    check("restart", {15'h0, rise}, 16'h0001);
    host.write(8'h47, 16'h00F8, 1);
    iout = 16'hE3F0;
    repeat (20) @(negedge clk);
    check("trip", {15'h0, oe}, 16'h0000);
    wait_hi(rise, 1);
    check("retry", {15'h0, rise}, 16'h0001);
    iout = 16'hE100;
    start_req = 0;
    repeat (10) @(negedge clk);
    results();
  end
endmodule // pmbus_command_bank_tb_top
bind pmbus_command_bank pmbus_command_bank_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
  .clk(clk), .rst_b(rst_b), .sda_oe(sda_oe), .start_req(start_req), .vout_meas(vout_meas),
  .output_enable(output_enable), .rise_active(rise_active), .power_good(power_good),
  .secondary_on_off_pin(secondary_on_off_pin));
`default_nettype wire
